//--- rtl/dpmb_host.sv
/*
  Host controller for one port of a dual-port mailbox RAM. Takes a read or
  write command, sequences select, write strobe and output enable, waits out
  the collision indication, and reports read data and the mailbox flag.
  Assumes pin inputs are synchronous to sys_clk and the bench resolves the
  data bus from the enable (low = host drives).
*/
`timescale 1ns/100ps
module dpmb_host (
  input  wire  logic                 sys_clk,      // System clock, 25 MHz
  input  wire  logic                 arst_n,       // Async reset, active low
  input  wire  dpmb_pkg::dpmb_cmd_t  cmd,          // Command from user
  input  wire  logic                 cmd_valid,    // Command offered
  output logic                       cmd_ready,    // Idle, command taken
  output logic [7:0]                 rd_data,      // Read result
  output logic                       done,         // Pulse at end of access
  output logic                       mail_pending, // Mailbox flag seen low
  output dpmb_pkg::dpmb_pins_t       pins,         // Control and address pins
  output logic [7:0]                 data_out,     // Data bus, host drive
  output logic                       data_oe_n,    // Low while host drives
  input  wire  logic [7:0]           data_in,      // Data bus, sampled
  input  wire  logic                 collision_n,  // Collision indication
  input  wire  logic                 mail_flag_n   // Mailbox flag of this port
);
  import dpmb_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_WAIT, S_PULSE, S_HOLD, S_READ} dpmb_state_t;

  dpmb_state_t state_r;
  dpmb_cmd_t   cmd_r;
  logic [3:0]  cnt_r;
  logic        coll_seen_r;

  assign cmd_ready = (state_r == S_IDLE);

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Address is loaded in idle with strobe high; strobe only drops after settling
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r     <= S_IDLE;
      cmd_r       <= '0;
      cnt_r       <= 4'h0;
      coll_seen_r <= 1'b0;
    end else begin
      unique case (state_r)
        S_IDLE: begin
          coll_seen_r <= 1'b0;
          if (cmd_valid) begin
            cmd_r   <= cmd;
            cnt_r   <= SETTLE_CYC;
            state_r <= S_SETUP;
          end
        end
        S_SETUP: begin
          // Collision settles from address before any strobe
          if (cnt_r > 4'h1) begin
            cnt_r <= cnt_r - 4'h1;
          end else begin
            cnt_r   <= cmd_r.write ? PULSE_CYC : READ_CYC;
            state_r <= cmd_r.write ? S_PULSE : S_WAIT;
          end
        end
        S_WAIT: begin
          // Read: wait access, then release-to-data after a collision
          if (!collision_n) begin
            coll_seen_r <= 1'b1;
            cnt_r       <= REL_CYC;
          end else if (cnt_r > 4'h1) begin
            cnt_r <= cnt_r - 4'h1;
          end else begin
            state_r <= S_READ;
          end
        end
        S_PULSE: begin
          // Pulse stretched for turn-off plus setup; restart hold on collision
          if (!collision_n) begin
            coll_seen_r <= 1'b1;
            cnt_r       <= HOLD_CYC;
          end else if (cnt_r > 4'h1) begin
            cnt_r <= cnt_r - 4'h1;
          end else if (coll_seen_r) begin
            cnt_r   <= HOLD_CYC;
            state_r <= S_HOLD;
          end else begin
            state_r <= S_READ;
          end
        end
        S_HOLD: begin
          // Keep strobe low after collision returns high
          if (!collision_n) begin
            cnt_r <= HOLD_CYC;
          end else if (cnt_r > 4'h1) begin
            cnt_r <= cnt_r - 4'h1;
          end else begin
            state_r <= S_READ;
          end
        end
        S_READ: begin
          state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pins
  // ---------------------------------------------------------------
  // Select low from setup; strobe low only in pulse and hold, after select
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pins      <= '{select_n: 1'b1, write_n: 1'b1, out_en_n: 1'b1, addr: '0};
      data_out  <= 8'h00;
      data_oe_n <= 1'b1;
    end else begin
      pins.addr <= (state_r == S_IDLE && cmd_valid) ? cmd.addr : pins.addr;
      if (state_r == S_IDLE) begin
        pins.select_n <= !cmd_valid;
      end else if (state_r == S_READ) begin
        pins.select_n <= 1'b1;
      end
      pins.write_n  <= !((state_r == S_SETUP && cnt_r == 4'h1 && cmd_r.write) ||
                         ((state_r == S_PULSE || state_r == S_HOLD) &&
                          !(state_r == S_HOLD && collision_n && cnt_r == 4'h1) &&
                          !(state_r == S_PULSE && collision_n && cnt_r == 4'h1 && !coll_seen_r)));
      // Output enable held high during writes so the bus is ours
      pins.out_en_n <= !((state_r == S_SETUP && !cmd_r.write) || state_r == S_WAIT);
      data_out      <= cmd_r.wdata;
      data_oe_n     <= !(cmd_r.write && state_r != S_IDLE && state_r != S_READ);
    end
  end

  // ---------------------------------------------------------------
  // Results
  // ---------------------------------------------------------------
  // Read data, done pulse, and mailbox flag tracking
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data      <= 8'h00;
      done         <= 1'b0;
      mail_pending <= 1'b0;
    end else begin
      done         <= (state_r == S_READ);
      mail_pending <= !mail_flag_n;
      if (state_r == S_WAIT && collision_n && cnt_r == 4'h1) begin
        rd_data <= data_in;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_addr_stable: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (!pins.write_n && !$past(pins.write_n)) |-> $stable(pins.addr))
    else $error("address moved while strobe low");

  a_strobe_after_sel: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $fell(pins.write_n) |-> !pins.select_n && $past(!pins.select_n))
    else $error("strobe fell before settling time");

  a_sel_before_wr: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $fell(pins.select_n) |-> pins.write_n)
    else $error("select fell with strobe already low");

  a_pulse_width: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $fell(pins.write_n) |-> !pins.write_n [*2])
    else $error("write pulse too short");

  a_hold_after_rel: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ($rose(collision_n) && !pins.write_n) |=> !pins.write_n)
    else $error("strobe released at collision release");

  a_wr_held_coll: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (!pins.write_n && !collision_n) |=> !pins.write_n)
    else $error("strobe released during collision");

  a_oe_needs_sel: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !pins.out_en_n |-> !pins.select_n && pins.write_n)
    else $error("enable low without select or during write");

  a_no_oe_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !pins.write_n |-> pins.out_en_n && !data_oe_n)
    else $error("enable low or bus idle during write");

  a_idle_select: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state_r == S_IDLE && !cmd_valid) |=> pins.select_n)
    else $error("select low with no command");

  a_done_bound: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (cmd_valid && cmd_ready && collision_n) ##1 collision_n [*4] |-> ##1 done)
    else $error("access did not complete");

  a_sel_wraps_wr: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !pins.write_n |-> !pins.select_n)
    else $error("strobe low without select");
endmodule

//--- rtl/dpmb_pkg.sv
/*
  Package for the dual-port mailbox RAM host controller: geometry, mailbox
  addresses, timing figures and derived cycle counts, command and pin structs.
  Assumes a 25 MHz system clock.
*/
package dpmb_pkg;
  // ---------------------------------------------------------------
  // Geometry and mailbox
  // ---------------------------------------------------------------
  localparam int          ADDR_W        = 11;
  localparam int          DATA_W        = 8;
  localparam logic [10:0] LEFT_MAIL_ADDR  = 11'h7fe;
  localparam logic [10:0] RIGHT_MAIL_ADDR = 11'h7ff;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS        = 40;
  localparam int COLLISION_SETTLE_NS  = 20;  // Collision settles from address
  localparam int WRITE_PULSE_NS       = 30;  // Least write pulse
  localparam int OUT_OFF_NS           = 30;  // Output turn-off from strobe
  localparam int DATA_SETUP_NS        = 20;  // Data valid to end of write
  localparam int POST_COLLISION_HOLD_NS = 20;
  localparam int READ_ACCESS_NS       = 55;
  localparam int COLLISION_RELEASE_TO_DATA_NS = 35;

  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int PULSE_NS_EFF = (WRITE_PULSE_NS > OUT_OFF_NS + DATA_SETUP_NS) ?
                                WRITE_PULSE_NS : (OUT_OFF_NS + DATA_SETUP_NS);
  localparam logic [3:0] SETTLE_CYC = 4'(ns_to_cyc(COLLISION_SETTLE_NS));
  localparam logic [3:0] PULSE_CYC  = 4'(ns_to_cyc(PULSE_NS_EFF));
  localparam logic [3:0] HOLD_CYC   = 4'(ns_to_cyc(POST_COLLISION_HOLD_NS));
  localparam logic [3:0] READ_CYC   = 4'(ns_to_cyc(READ_ACCESS_NS));
  localparam logic [3:0] REL_CYC    = 4'(ns_to_cyc(COLLISION_RELEASE_TO_DATA_NS));

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              write;
    logic [10:0]       addr;
    logic [7:0]        wdata;
  } dpmb_cmd_t;

  typedef struct packed {
    logic              select_n;
    logic              write_n;
    logic              out_en_n;
    logic [10:0]       addr;
  } dpmb_pins_t;
endpackage

//--- bench/dpmb_ram_model.sv
/*
  Dual-port mailbox RAM with arbitration, facing two hosts.
  Assumes both hosts run on sys_clk.
*/
`timescale 1ns/100ps
module dpmb_ram_model (
  input  wire logic                 sys_clk,           // Host clock
  input  wire dpmb_pkg::dpmb_pins_t pins_l,            // Left pins
  input  wire dpmb_pkg::dpmb_pins_t pins_r,            // Right pins
  input  wire logic [7:0]           dout_l,            // Left host data
  input  wire logic [7:0]           dout_r,            // Right host data
  input  wire logic                 doe_l_n,           // Left host drives
  input  wire logic                 doe_r_n,           // Right host drives
  output logic [7:0]                din_l,             // Left bus level
  output logic [7:0]                din_r,             // Right bus level
  output logic                      left_collision_n,  // Left waits
  output logic                      right_collision_n, // Right waits
  output logic                      left_mail_flag_n,  // Mail for left
  output logic                      right_mail_flag_n  // Mail for right
);
  import dpmb_pkg::*;
  // -----
  // Array and arbitration
  // -----
  logic [7:0] mem [0:2047];
  logic [7:0] last_l;
  logic [7:0] last_r;
  logic       prev_l  = 1'b0;
  logic [1:0] owner_r = 2'h0;
  logic [1:0] owner;
  logic       sel_l;
  logic       sel_r;
  logic       match;
  // Select and address only decide a collision
  assign sel_l = !pins_l.select_n;
  assign sel_r = !pins_r.select_n;
  assign match = sel_l && sel_r && (pins_l.addr == pins_r.addr);
  // Earlier port keeps access, a tie goes right
  assign owner = (owner_r != 2'h0) ? owner_r : (prev_l ? 2'h1 : 2'h2);
  // Only one side waits
  assign left_collision_n  = !(match && owner == 2'h2);
  assign right_collision_n = !(match && owner == 2'h1);
  // History for arbitration and the floating bus
  always @(posedge sys_clk) begin
    prev_l  <= sel_l;
    owner_r <= match ? owner : 2'h0;
    last_l  <= din_l;
    last_r  <= din_r;
  end
  // Bus: host, device read unless waiting (stale), else inverse of last
  assign din_l = !doe_l_n ? dout_l :
                 (sel_l && pins_l.write_n && !pins_l.out_en_n && left_collision_n) ? mem[pins_l.addr] : ~last_l;
  assign din_r = !doe_r_n ? dout_r :
                 (sel_r && pins_r.write_n && !pins_r.out_en_n && right_collision_n) ? mem[pins_r.addr] : ~last_r;
  initial left_mail_flag_n = 1'b1;
  initial right_mail_flag_n = 1'b1;
  // Writes on strobe overlap, held off while waiting
  always @(posedge sys_clk) begin
    if (sel_l && !pins_l.write_n && left_collision_n) begin
      mem[pins_l.addr] <= din_l;
      if (pins_l.addr == RIGHT_MAIL_ADDR) right_mail_flag_n <= 1'b0;
    end
    if (sel_r && !pins_r.write_n && right_collision_n) begin
      mem[pins_r.addr] <= din_r;
      if (pins_r.addr == LEFT_MAIL_ADDR) left_mail_flag_n <= 1'b0;
    end
    if (sel_r && !pins_r.out_en_n && pins_r.addr == RIGHT_MAIL_ADDR) right_mail_flag_n <= 1'b1;
    if (sel_l && !pins_l.out_en_n && pins_l.addr == LEFT_MAIL_ADDR) left_mail_flag_n <= 1'b1;
  end
endmodule

//--- bench/dpmb_host_tb.sv
/*
  Bench: two hosts share the RAM model; a reference array predicts reads.
  Assumes dpmb_pkg and the RAM model compile first.
*/
`timescale 1ns/100ps
module dpmb_host_tb;
  import dpmb_pkg::*;
  logic       sys_clk = 1'b0;
  logic       arst_n  = 1'b0;
  dpmb_cmd_t  cmd [2];
  logic       cmd_valid [2], cmd_ready [2], done [2], pend [2], oe_n [2];
  logic [7:0] rd_data [2], dout [2], din [2];
  logic       coll_n [2], flag_n [2];
  dpmb_pins_t pins [2];
  logic [10:0] a, m;
  int         ref_mem [2048];
  int         errors = 0, comparisons = 0, cyc = 0;
  always #20 sys_clk = ~sys_clk;
  dpmb_host dut (.sys_clk(sys_clk), .arst_n(arst_n), .cmd(cmd[0]), .cmd_valid(cmd_valid[0]),
    .cmd_ready(cmd_ready[0]), .rd_data(rd_data[0]), .done(done[0]), .mail_pending(pend[0]), .pins(pins[0]),
    .data_out(dout[0]), .data_oe_n(oe_n[0]), .data_in(din[0]), .collision_n(coll_n[0]), .mail_flag_n(flag_n[0]));
  dpmb_host dut_r (.sys_clk(sys_clk), .arst_n(arst_n), .cmd(cmd[1]), .cmd_valid(cmd_valid[1]),
    .cmd_ready(cmd_ready[1]), .rd_data(rd_data[1]), .done(done[1]), .mail_pending(pend[1]), .pins(pins[1]),
    .data_out(dout[1]), .data_oe_n(oe_n[1]), .data_in(din[1]), .collision_n(coll_n[1]), .mail_flag_n(flag_n[1]));
  dpmb_ram_model ram (.sys_clk(sys_clk), .pins_l(pins[0]), .pins_r(pins[1]), .dout_l(dout[0]), .dout_r(dout[1]),
    .doe_l_n(oe_n[0]), .doe_r_n(oe_n[1]), .din_l(din[0]), .din_r(din[1]), .left_collision_n(coll_n[0]),
    .right_collision_n(coll_n[1]), .left_mail_flag_n(flag_n[0]), .right_mail_flag_n(flag_n[1]));
  // Cuts a hang short
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      results();
    end
  end
  task automatic results();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %s saw %h wanted %h", $time, what, seen, exp);
    end
  endtask
  // One access on port s; a read is compared with the reference
  task automatic op(input int s, input logic w, input logic [10:0] ad, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (cmd_ready[s] !== 1'b1) @(negedge sys_clk);
    cmd[s] = '{w, ad, d};
    cmd_valid[s] = 1'b1;
    @(negedge sys_clk);
    cmd_valid[s] = 1'b0;
    while (done[s] !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    check(done[s], 8'h01, "done");
    if (w) ref_mem[ad] = d;
    else check(rd_data[s], 8'(ref_mem[ad]), "read");
  endtask
  // -----
  // Main sequence
  // -----
  initial begin
    cmd[0] = '0;
    cmd[1] = '0;
    cmd_valid[0] = 1'b0;
    cmd_valid[1] = 1'b0;
    void'($urandom(53));
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    arst_n = 1'b1;
    // Bytes cross between ports, address 000 and the last address below the mailboxes (7fd) included
    for (int i = 0; i < 12; i++) begin
      a = (i == 0) ? 11'h000 : (i == 1) ? 11'h7fd : 11'($urandom_range(2045));
      op(i % 2, 1'b1, a, 8'($urandom));
      op(1 - i % 2, 1'b0, a, 8'h00);
    end
    // Mail each way, then the owner reads its box
    for (int s = 0; s < 2; s++) begin
      m = s ? LEFT_MAIL_ADDR : RIGHT_MAIL_ADDR;
      op(s, 1'b1, m, 8'($urandom));
      @(negedge sys_clk);
      check(pend[1 - s], 8'h01, "mail raised");
      op(1 - s, 1'b0, m, 8'h00);
      @(negedge sys_clk);
      check(pend[1 - s], 8'h00, "mail cleared");
    end
    // Both write one address at once; the waiting side must still land
    repeat (4) begin
      a = 11'($urandom_range(2045));
      fork
        op(0, 1'b1, a, 8'($urandom));
        op(1, 1'b1, a, 8'($urandom));
      join
      op(1, 1'b0, a, 8'h00);
      // Left reads while right writes: the waiting reader must get the new byte
      fork
        op(0, 1'b0, a, 8'h00);
        op(1, 1'b1, a, 8'($urandom));
      join
    end
    results();
  end
endmodule
